//--- hdl/scrl_pkg.sv
// Shared constants and carrier types of the serial control register logic.
// Assumes an AXI4-Lite register bus with 32-bit data and a 4-bit byte address.
package scrl_pkg;

	// ****************************************
	// Register map and bus answers
	// ****************************************
	localparam logic [3:0] SCRL_OFS_CTRL   = 4'h0;
	localparam logic [3:0] SCRL_OFS_FMT    = 4'h4;
	localparam logic [3:0] SCRL_OFS_STATUS = 4'h8;
	localparam logic [3:0] SCRL_OFS_TXHOLD = 4'hC;
	localparam logic [1:0] SCRL_RESP_OKAY  = 2'h0;
	localparam logic [1:0] SCRL_RESP_SLVERR = 2'h2;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] SCRL_CTRL_RST   = 8'h00;
	localparam logic [7:0] SCRL_FMT_RST    = 8'h00;
	localparam logic [7:0] SCRL_STATUS_RST = 8'h84;
	localparam logic [7:0] SCRL_TXHOLD_RST = 8'hFF;
	localparam logic [7:0] SCRL_RXHOLD_RST = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CB_TXE_IE   = 7;
	localparam int CB_RXF_IE   = 6;
	localparam int CB_TX_EN    = 5;
	localparam int CB_RX_EN    = 4;
	localparam int CB_ADDR_WT  = 3;
	localparam int CB_TXD_IE   = 2;
	localparam int CB_CLK_EXT  = 1;
	localparam int CB_CLK_OUT  = 0;
	localparam int FB_SYNC     = 7;
	localparam int FB_MPROC    = 2;
	localparam int SB_TXEMPTY  = 7;
	localparam int SB_RXFULL   = 6;
	localparam int SB_OVERRUN  = 5;
	localparam int SB_FRAMING  = 4;
	localparam int SB_PARITY   = 3;
	localparam int SB_TXDONE   = 2;
	localparam int SB_ADDRBIT  = 1;
	localparam int SB_ADDRTX   = 0;

	// Flags that software may clear by writing zero after reading one.
	localparam logic [7:0] SCRL_CLEARABLE = 8'hF8;

	// Events delivered by the shifters and baud generator.
	typedef struct packed {
		logic       tx_idle;
		logic       tx_last_bit;
		logic       rx_done;
		logic [7:0] rx_data;
		logic       rx_addr;
		logic       rx_frame_err;
		logic       rx_parity_err;
		logic       brg_half_tick;
	} scrl_shift_in_type;

	// Interrupt request levels.
	typedef struct packed {
		logic txempty_irq;
		logic rxfull_irq;
		logic rxerror_irq;
		logic txdone_irq;
	} scrl_irq_type;

endpackage

//--- hdl/scrl_pin_sync.sv
// Two-stage synchroniser with an edge detector for one pin.
// Assumes the pin is asynchronous to sys_clk; edges are found on the second stage.
`timescale 1ns/100ps

module scrl_pin_sync
	import scrl_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic pin_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} scrl_sync_type;

	scrl_sync_type state_ff;
	scrl_sync_type nxt_state;

	// The first stage is read only by the second stage.
	always_comb begin
		nxt_state      = state_ff;
		nxt_state.meta = pin_in;
		nxt_state.sync = state_ff.meta;
		nxt_state.last = state_ff.sync;
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '{meta: 1'b1, sync: 1'b1, last: 1'b1};
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	// Outputs taken from the settled stages.
	assign level = state_ff.sync;
	assign rise  = state_ff.sync & ~state_ff.last;
	assign fall  = ~state_ff.sync & state_ff.last;

endmodule // scrl_pin_sync

//--- hdl/scrl_ctrl.sv
// Serial control register logic with its format, status and data registers.
// Assumes shifters and a baud generator on sys_clk, and an AXI4-Lite master.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps

// How it works
// RL1: Control register clears to zero on reset and on low-power entry.
// RL2: Transmit-empty request needs its enable and the empty flag.
// RL3: Transmit-empty request drops on flag read-then-clear or enable cleared.
// RL4: Receive-full interrupt enable bit gates both receive-full and receive-error requests.
// RL5: Receive requests drop when the flag is read-then-cleared or enable cleared.
// RL6: With transmit disabled the empty flag stays set and nothing is sent.
// RL7: Transmit enabled: data loads into shifter once empty flag is cleared.
// RL8: Software sets the transfer format before enabling transmit.
// RL9: Clearing receive enable leaves all receive flags unchanged.
// RL10: Reception starts on start bit (async) or incoming clock (sync).
// RL11: Software sets the reception format before enabling receive.
// RL12: Address wait acts only in async multiprocessor reception.
// RL13: During address wait, data characters are dropped without flags.
// RL14: An address character sets the address bit and ends address wait.
// RL15: Transmit-done request needs its enable and the done flag.
// RL16: Transmit-done request drops when flags clear or its enable clears.
// RL17: Clock bits choose internal or external clock and the pin role.
// RL18: Clock output select matters only for internal async clocking.
// RL19: Async internal clock output toggles at the bit rate.
// RL20: External async clock must be sixteen times the bit rate.
// RL21: Clock bits are set before the operating mode is fixed.
// RL22: Format bit seven picks asynchronous or clocked synchronous operation.
// RL23: Each request is its flag AND its enable, registered.
module scrl_ctrl
	import scrl_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	input  wire logic               lowpower_clr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [3:0]         s_axi_awaddr,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	output logic [1:0]              s_axi_bresp,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	input  wire logic [3:0]         s_axi_araddr,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	input  wire scrl_shift_in_type  shift_in,
	output logic                    tx_load,
	output logic [7:0]              tx_data,
	output logic                    rx_start,
	output logic                    ext_clk_edge,
	output logic [7:0]              fmt_bits,
	output logic                    tx_enable,
	output logic                    rx_enable,
	input  wire logic               rxd_pin,
	input  wire logic               serial_clock_pin_i,
	output logic                    serial_clock_pin_o,
	output logic                    serial_clock_pin_oe_n,
	output scrl_irq_type            irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]   ctrl;
		logic [7:0]   fmt;
		logic [7:0]   status;
		logic [7:0]   armed;
		logic [7:0]   txhold;
		logic [7:0]   rxhold;
		logic         aw_have;
		logic [3:0]   aw_addr;
		logic         w_have;
		logic [7:0]   w_data;
		logic         w_lane0;
		logic         awready;
		logic         wready;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         arready;
		logic         rvalid;
		logic [31:0]  rdata;
		logic [1:0]   rresp;
		logic         tx_load;
		logic [7:0]   tx_data;
		logic         rx_start;
		logic         ext_edge;
		logic         sck_o;
		logic         sck_oe_n;
		scrl_irq_type irq;
	} scrl_state_type;

	scrl_state_type state_ff;
	scrl_state_type nxt_state;

	logic rxd_level;
	logic rxd_fall;
	logic sck_rise;
	logic sck_fall;

	// Decodes a byte address into the mapped register set.
	function automatic logic scrl_mapped(input logic [3:0] addr);
		scrl_mapped = (addr == SCRL_OFS_CTRL) || (addr == SCRL_OFS_FMT) ||
		              (addr == SCRL_OFS_STATUS) || (addr == SCRL_OFS_TXHOLD);
	endfunction

	// Returns the register value seen by a read at an address.
	function automatic logic [7:0] scrl_read(input scrl_state_type s, input logic [3:0] addr);
		case (addr)
			SCRL_OFS_CTRL: begin
				scrl_read = s.ctrl;
			end
			SCRL_OFS_FMT: begin
				scrl_read = s.fmt;
			end
			SCRL_OFS_STATUS: begin
				scrl_read = s.status;
			end
			SCRL_OFS_TXHOLD: begin
				scrl_read = s.txhold;
			end
			default: begin
				scrl_read = 8'h00;
			end
		endcase
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	scrl_pin_sync u_rxd_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.pin_in  (rxd_pin),
		.level   (rxd_level),
		.rise    (),
		.fall    (rxd_fall)
	);

	scrl_pin_sync u_sck_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.pin_in  (serial_clock_pin_i),
		.level   (),
		.rise    (sck_rise),
		.fall    (sck_fall)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic sync_mode;
		logic clk_ext;
		logic addr_wait;
		logic drive_clk;
		logic wr_fire;
		logic [7:0] st_clr;
		sync_mode = state_ff.fmt[FB_SYNC]; // RL22
		clk_ext   = state_ff.ctrl[CB_CLK_EXT];
		addr_wait = state_ff.ctrl[CB_ADDR_WT] & state_ff.fmt[FB_MPROC] & ~sync_mode; // RL12
		drive_clk = 1'b0;
		wr_fire   = 1'b0;
		st_clr    = 8'h00;
		nxt_state = state_ff;
		nxt_state.tx_load  = 1'b0;
		nxt_state.rx_start = 1'b0;
		nxt_state.ext_edge = 1'b0;

		// Write address and data are taken independently.
		if (s_axi_awvalid && state_ff.awready) begin
			nxt_state.aw_have = 1'b1;
			nxt_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && state_ff.wready) begin
			nxt_state.w_have  = 1'b1;
			nxt_state.w_data  = s_axi_wdata[7:0];
			nxt_state.w_lane0 = s_axi_wstrb[0];
		end
		if (state_ff.bvalid && s_axi_bready) begin
			nxt_state.bvalid = 1'b0;
		end

		// A complete write posts the response and, when byte lane 0 is strobed, updates the register.
		if (state_ff.aw_have && state_ff.w_have && !state_ff.bvalid) begin
			wr_fire           = 1'b1;
			nxt_state.aw_have = 1'b0;
			nxt_state.w_have  = 1'b0;
			nxt_state.bvalid  = 1'b1;
			nxt_state.bresp   = scrl_mapped(state_ff.aw_addr) ? SCRL_RESP_OKAY : SCRL_RESP_SLVERR;
		end
		if (wr_fire && state_ff.w_lane0) begin
			case (state_ff.aw_addr)
				SCRL_OFS_CTRL: begin
					nxt_state.ctrl = state_ff.w_data;
				end
				SCRL_OFS_FMT: begin
					nxt_state.fmt = state_ff.w_data;
				end
				SCRL_OFS_STATUS: begin
					// Only flags read as one may be cleared by a zero.
					st_clr = ~state_ff.w_data & state_ff.armed & SCRL_CLEARABLE; // RL3 RL5
					nxt_state.status = state_ff.status & ~st_clr;
					nxt_state.status[SB_ADDRTX] = state_ff.w_data[SB_ADDRTX];
					nxt_state.armed = 8'h00;
				end
				SCRL_OFS_TXHOLD: begin
					nxt_state.txhold = state_ff.w_data;
				end
				default: begin
					nxt_state.txhold = state_ff.txhold;
				end
			endcase
		end

		// Clearing the empty flag also clears the done flag.
		if (st_clr[SB_TXEMPTY]) begin
			nxt_state.status[SB_TXDONE] = 1'b0; // RL16
		end

		// Read channel; a status read arms the clearable flags that read as one.
		if (state_ff.rvalid && s_axi_rready) begin
			nxt_state.rvalid = 1'b0;
		end
		if (s_axi_arvalid && state_ff.arready) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rdata  = {24'h000000, scrl_read(state_ff, s_axi_araddr)};
			nxt_state.rresp  = scrl_mapped(s_axi_araddr) ? SCRL_RESP_OKAY : SCRL_RESP_SLVERR;
			if (s_axi_araddr == SCRL_OFS_STATUS) begin
				nxt_state.armed = state_ff.status & SCRL_CLEARABLE;
			end
		end

		// Transmit side; hardware sets are applied after software clears.
		if (!state_ff.ctrl[CB_TX_EN]) begin
			nxt_state.status[SB_TXEMPTY] = 1'b1; // RL6
		end else if (!state_ff.status[SB_TXEMPTY] && shift_in.tx_idle) begin
			nxt_state.tx_load = 1'b1; // RL7
			nxt_state.tx_data = state_ff.txhold;
			nxt_state.status[SB_TXEMPTY] = 1'b1; // RL2
		end
		if (shift_in.tx_last_bit && state_ff.status[SB_TXEMPTY]) begin
			nxt_state.status[SB_TXDONE] = 1'b1; // RL15
		end

		// Receive side; clearing receive enable touches no flag.
		if (shift_in.rx_done && state_ff.ctrl[CB_RX_EN]) begin // RL9
			if (addr_wait && !shift_in.rx_addr) begin
				nxt_state.status = nxt_state.status; // RL13
			end else begin
				if (state_ff.fmt[FB_MPROC] && !sync_mode) begin
					nxt_state.status[SB_ADDRBIT] = shift_in.rx_addr;
				end
				if (addr_wait) begin
					nxt_state.ctrl[CB_ADDR_WT] = 1'b0; // RL14
				end
				if (state_ff.status[SB_RXFULL]) begin
					nxt_state.status[SB_OVERRUN] = 1'b1;
				end else if (shift_in.rx_frame_err && !sync_mode) begin
					nxt_state.status[SB_FRAMING] = 1'b1;
					nxt_state.rxhold = shift_in.rx_data;
				end else if (shift_in.rx_parity_err && !sync_mode && !state_ff.fmt[FB_MPROC]) begin
					nxt_state.status[SB_PARITY] = 1'b1;
					nxt_state.rxhold = shift_in.rx_data;
				end else begin
					nxt_state.status[SB_RXFULL] = 1'b1;
					nxt_state.rxhold = shift_in.rx_data;
				end
			end
		end

		// Start of reception: start bit in async, external clock falling edge in sync.
		if (state_ff.ctrl[CB_RX_EN] && !(|state_ff.status[SB_OVERRUN:SB_PARITY])) begin
			if (sync_mode) begin
				nxt_state.rx_start = clk_ext & sck_fall; // RL10
			end else begin
				nxt_state.rx_start = rxd_fall; // RL10
			end
		end

		// Clock pin role and the internal bit-rate clock output.
		drive_clk = ~clk_ext & (sync_mode | state_ff.ctrl[CB_CLK_OUT]); // RL17 RL18
		nxt_state.sck_oe_n = ~drive_clk;
		if (!drive_clk) begin
			nxt_state.sck_o = 1'b1;
		end else if (shift_in.brg_half_tick) begin
			nxt_state.sck_o = ~state_ff.sck_o; // RL19
		end
		nxt_state.ext_edge = clk_ext & sck_rise; // RL20

		// Low-power entry returns every register to its reset value.
		if (lowpower_clr) begin
			nxt_state.ctrl   = SCRL_CTRL_RST; // RL1
			nxt_state.fmt    = SCRL_FMT_RST;
			nxt_state.status = SCRL_STATUS_RST;
			nxt_state.armed  = 8'h00;
			nxt_state.txhold = SCRL_TXHOLD_RST;
			nxt_state.rxhold = SCRL_RXHOLD_RST;
			nxt_state.tx_load  = 1'b0;
			nxt_state.rx_start = 1'b0;
		end

		// Requests are registered flag AND enable.
		nxt_state.irq.txempty_irq = nxt_state.status[SB_TXEMPTY] & nxt_state.ctrl[CB_TXE_IE]; // RL2 RL23
		nxt_state.irq.rxfull_irq  = nxt_state.status[SB_RXFULL] & nxt_state.ctrl[CB_RXF_IE]; // RL4 RL23
		nxt_state.irq.rxerror_irq = (|nxt_state.status[SB_OVERRUN:SB_PARITY]) & nxt_state.ctrl[CB_RXF_IE]; // RL4 RL5
		nxt_state.irq.txdone_irq  = nxt_state.status[SB_TXDONE] & nxt_state.ctrl[CB_TXD_IE]; // RL15 RL23

		// Ready flags reflect the next holding state.
		nxt_state.awready = ~nxt_state.aw_have & ~nxt_state.bvalid;
		nxt_state.wready  = ~nxt_state.w_have & ~nxt_state.bvalid;
		nxt_state.arready = ~nxt_state.rvalid;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff          <= '0;
			state_ff.ctrl     <= SCRL_CTRL_RST; // RL1
			state_ff.fmt      <= SCRL_FMT_RST;
			state_ff.status   <= SCRL_STATUS_RST;
			state_ff.txhold   <= SCRL_TXHOLD_RST;
			state_ff.rxhold   <= SCRL_RXHOLD_RST;
			state_ff.sck_o    <= 1'b1;
			state_ff.sck_oe_n <= 1'b1;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready         = state_ff.awready;
	assign s_axi_wready          = state_ff.wready;
	assign s_axi_bvalid          = state_ff.bvalid;
	assign s_axi_bresp           = state_ff.bresp;
	assign s_axi_arready         = state_ff.arready;
	assign s_axi_rvalid          = state_ff.rvalid;
	assign s_axi_rdata           = state_ff.rdata;
	assign s_axi_rresp           = state_ff.rresp;
	assign tx_load               = state_ff.tx_load;
	assign tx_data               = state_ff.tx_data;
	assign rx_start              = state_ff.rx_start;
	assign ext_clk_edge          = state_ff.ext_edge;
	assign fmt_bits              = state_ff.fmt;
	assign tx_enable             = state_ff.ctrl[CB_TX_EN];
	assign rx_enable             = state_ff.ctrl[CB_RX_EN];
	assign serial_clock_pin_o    = state_ff.sck_o;
	assign serial_clock_pin_oe_n = state_ff.sck_oe_n;
	assign irq                   = state_ff.irq;

	// The synchronised receive level is left unused; it drives no output and no logic.
	logic rxd_idle_unused;
	assign rxd_idle_unused = rxd_level;

endmodule // scrl_ctrl

//--- dv/scrl_ctrl_monitor.sv
// Concurrent checks on the ports of the serial control register logic.
// Assumes it is bound into scrl_ctrl; one clock, sys_clk, reset by rst_n low.
`timescale 1ns/100ps
module scrl_ctrl_monitor
	import scrl_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire logic              lowpower_clr,
	input wire scrl_shift_in_type shift_in,
	input wire logic              tx_load,
	input wire logic              rx_start,
	input wire logic              ext_clk_edge,
	input wire logic [7:0]        fmt_bits,
	input wire logic              tx_enable,
	input wire logic              rx_enable,
	input wire logic              serial_clock_pin_o,
	input wire logic              serial_clock_pin_oe_n,
	input wire scrl_irq_type      irq
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Two cycles of low-power clear; registers and request levels clear in the same cycle.
	sequence s_lp_twice;
		lowpower_clr [*2];
	endsequence

	// Pin driven in this and the previous cycle.
	sequence s_driving;
		!serial_clock_pin_oe_n && !$past(serial_clock_pin_oe_n);
	endsequence

	a_lp_clear: assert property (lowpower_clr |=> !tx_enable && !rx_enable && fmt_bits == 8'h00)
		else $error("Control bits survived a low-power clear.");
	a_lp_irq: assert property (s_lp_twice |=> irq == 4'h0)
		else $error("Request level stayed up after a low-power clear.");
	a_load_gated: assert property (tx_load |-> $past(tx_enable))
		else $error("Shifter load while transmit was disabled.");
	a_load_idle: assert property (tx_load |-> $past(shift_in.tx_idle))
		else $error("Shifter load while the shifter was busy.");
	a_start_gated: assert property (rx_start |-> $past(rx_enable))
		else $error("Reception start while receive was disabled.");
	a_edge_input: assert property (ext_clk_edge |-> serial_clock_pin_oe_n)
		else $error("External clock edge seen while the pin is driven.");
	a_sck_still: assert property (s_driving ##0 !$past(shift_in.brg_half_tick) |-> $stable(serial_clock_pin_o))
		else $error("Clock output moved without a rate tick.");
	a_sck_toggle: assert property (s_driving ##0 $past(shift_in.brg_half_tick) |-> !$stable(serial_clock_pin_o))
		else $error("Clock output missed a rate tick.");
endmodule // scrl_ctrl_monitor

bind scrl_ctrl scrl_ctrl_monitor u_mon (.sys_clk, .rst_n, .lowpower_clr, .shift_in, .tx_load, .rx_start,
	.ext_clk_edge, .fmt_bits, .tx_enable, .rx_enable, .serial_clock_pin_o, .serial_clock_pin_oe_n, .irq);

//--- dv/scrl_remote.sv
// Behavioural remote serial device on the data and clock pins.
// Assumes the bench requests each frame with a rising edge on frame_req.
`timescale 1ns/100ps
module scrl_remote
(
	input  wire logic frame_req,
	input  wire logic slow,
	output logic      rxd,
	output logic      sck
);
	// Both lines idle high as if pulled up; the clock stands still between frames.
	initial begin
		rxd = 1'b1;
		sck = 1'b1;
	end

	// A frame is a start bit held low over eight clock periods of 800 ns, or twice that when slow.
	always @(posedge frame_req) begin
		rxd = 1'b0;
		repeat (8) begin
			#(slow ? 800 : 400) sck = 1'b0;
			#(slow ? 800 : 400) sck = 1'b1;
		end
		rxd = 1'b1;
	end
endmodule // scrl_remote

//--- dv/scrl_ctrl_bench.sv
// Self-checking bench of the serial control register logic.
// Assumes the remote device model and the bound port monitor.
`timescale 1ns/100ps
module scrl_ctrl_bench
	import scrl_pkg::*;
;
	logic              sys_clk, rst_n, ce, lowpower_clr, frame_req, slow, remote_sck;
	logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0]       s_axi_wdata, s_axi_rdata, rnd;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              tx_load, rx_start, ext_clk_edge, tx_enable, rx_enable, rxd_pin, sck_q;
	logic              serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_n;
	logic [7:0]        tx_data, fmt_bits, ld_data, d;
	scrl_shift_in_type shift_in;
	scrl_irq_type      irq;
	logic [33:0]       exp_q[$];
	int                err_count, tests_run, cyc, loads, starts, edges, toggles;

	// ****************************************
	// Design, far side and pin level
	// ****************************************
	scrl_ctrl DUT (.sys_clk, .rst_n, .ce, .lowpower_clr, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .shift_in, .tx_load, .tx_data, .rx_start, .ext_clk_edge, .fmt_bits, .tx_enable,
		.rx_enable, .rxd_pin, .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe_n, .irq);
	scrl_remote u_remote (.frame_req, .slow, .rxd(rxd_pin), .sck(remote_sck));
	// The pin follows the design while it drives, else the remote clock.
	assign serial_clock_pin_i = serial_clock_pin_oe_n ? remote_sck : serial_clock_pin_o;

	// ****************************************
	// Clock, helpers and bus tasks
	// ****************************************
	initial sys_clk = 1'b0;
	always #50 sys_clk = ~sys_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Write: the expected response is noted; address and data are offered together, each released when taken.
	task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] r = SCRL_RESP_OKAY);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		exp_q.push_back({r, 32'h00000000});
		@(posedge sys_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, v};
		while (!(ad && dd)) begin
			@(posedge sys_clk);
			if (!ad && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!dd && s_axi_wready) begin
				dd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	// Read: the expected word is noted; the watcher compares it when it arrives.
	task automatic rd(input logic [3:0] a, input logic [7:0] v, input logic [1:0] r = SCRL_RESP_OKAY);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		exp_q.push_back({r, 24'h000000, v});
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask

	task automatic irq_is(input logic [3:0] e);
		repeat (2) @(posedge sys_clk);
		#1 chk({30'h0, irq}, {30'h0, e});
	endtask

	task automatic pin_is(input logic e);
		repeat (3) @(posedge sys_clk);
		#1 chk({33'h0, serial_clock_pin_oe_n}, {33'h0, e});
	endtask

	task automatic rxev(input logic a);
		@(posedge sys_clk);
		shift_in.rx_done <= 1'b1;
		shift_in.rx_addr <= a;
		shift_in.rx_data <= rnd[7:0];
		rnd = lfsr(rnd);
		@(posedge sys_clk);
		shift_in.rx_done <= 1'b0;
	endtask

	task automatic lp();
		@(posedge sys_clk);
		lowpower_clr <= 1'b1;
		repeat (2) @(posedge sys_clk);
		lowpower_clr <= 1'b0;
	endtask

	// Watcher: takes the oldest note at each bus answer, counts pulses, makes rate ticks, limits the run.
	always @(posedge sys_clk) begin
		cyc++;
		shift_in.brg_half_tick <= (cyc[2:0] == 3'h0);
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			chk({s_axi_bresp, 32'h00000000}, exp_q.pop_front());
		if (tx_load) begin
			loads++;
			ld_data = tx_data;
		end
		starts += rx_start;
		edges += ext_clk_edge;
		toggles += (!serial_clock_pin_oe_n && serial_clock_pin_o !== sck_q);
		sck_q = serial_clock_pin_o;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		{rst_n, lowpower_clr, frame_req, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		shift_in = '0;
		ce = 1'b1;
		s_axi_wstrb = 4'hF;
		rnd = 32'hBD8DB059;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(SCRL_OFS_CTRL, 8'h00);
		rd(SCRL_OFS_STATUS, 8'h84);
		rd(4'h2, 8'h00, SCRL_RESP_SLVERR);
		wr(4'h2, 8'hFF, SCRL_RESP_SLVERR);
		d = rnd[7:0];
		rnd = lfsr(rnd);
		wr(SCRL_OFS_CTRL, d);
		rd(SCRL_OFS_CTRL, d);
		lp();
		rd(SCRL_OFS_CTRL, 8'h00);
		$display("Test reset done");
		d = rnd[7:0];
		wr(SCRL_OFS_TXHOLD, d);
		wr(SCRL_OFS_FMT, 8'h00);
		wr(SCRL_OFS_CTRL, 8'hA0);
		irq_is(4'h8);
		rd(SCRL_OFS_STATUS, 8'h84);
		wr(SCRL_OFS_STATUS, 8'h00);
		irq_is(4'h0);
		rd(SCRL_OFS_STATUS, 8'h00);
		shift_in.tx_idle <= 1'b1;
		irq_is(4'h8);
		chk(34'(loads), 34'd1);
		chk({26'h0, ld_data}, {26'h0, d});
		wr(SCRL_OFS_CTRL, 8'h80);
		rd(SCRL_OFS_STATUS, 8'h80);
		wr(SCRL_OFS_STATUS, 8'h00);
		rd(SCRL_OFS_STATUS, 8'h80);
		chk(34'(loads), 34'd1);
		wr(SCRL_OFS_CTRL, 8'h24);
		@(posedge sys_clk);
		shift_in.tx_last_bit <= 1'b1;
		@(posedge sys_clk);
		shift_in.tx_last_bit <= 1'b0;
		irq_is(4'h1);
		wr(SCRL_OFS_CTRL, 8'h20);
		irq_is(4'h0);
		$display("Test transmit done");
		wr(SCRL_OFS_CTRL, 8'h50);
		rxev(1'b0);
		irq_is(4'h4);
		wr(SCRL_OFS_CTRL, 8'h40);
		rd(SCRL_OFS_STATUS, 8'hC4);
		wr(SCRL_OFS_CTRL, 8'h50);
		rxev(1'b0);
		irq_is(4'h6);
		rd(SCRL_OFS_STATUS, 8'hE4);
		wr(SCRL_OFS_STATUS, 8'h00);
		irq_is(4'h0);
		lp();
		wr(SCRL_OFS_FMT, 8'h04);
		wr(SCRL_OFS_CTRL, 8'h58);
		rxev(1'b0);
		irq_is(4'h0);
		rd(SCRL_OFS_CTRL, 8'h58);
		rxev(1'b1);
		rd(SCRL_OFS_CTRL, 8'h50);
		irq_is(4'h4);
		lp();
		wr(SCRL_OFS_CTRL, 8'h50);
		shift_in.rx_frame_err <= 1'b1;
		shift_in.rx_parity_err <= 1'b1;
		rxev(1'b0);
		shift_in.rx_frame_err <= 1'b0;
		irq_is(4'h2);
		rxev(1'b0);
		shift_in.rx_parity_err <= 1'b0;
		rd(SCRL_OFS_STATUS, 8'h9C);
		$display("Test receive done");
		lp();
		wr(SCRL_OFS_CTRL, 8'h01);
		pin_is(1'b0);
		repeat (40) @(posedge sys_clk);
		chk(34'(toggles > 0), 34'd1);
		wr(SCRL_OFS_CTRL, 8'h00);
		pin_is(1'b1);
		wr(SCRL_OFS_FMT, 8'h80);
		pin_is(1'b0);
		wr(SCRL_OFS_CTRL, 8'h03);
		pin_is(1'b1);
		wr(SCRL_OFS_FMT, 8'h00);
		wr(SCRL_OFS_CTRL, 8'h12);
		starts = 0;
		edges = 0;
		for (int i = 0; i < 3; i++) begin
			if (i == 2)
				wr(SCRL_OFS_FMT, 8'h80);
			slow <= i[0];
			frame_req <= 1'b1;
			@(posedge sys_clk);
			frame_req <= 1'b0;
			repeat (200) @(posedge sys_clk);
		end
		chk(34'(edges), 34'd24);
		chk(34'(starts), 34'd10);
		$display("Test clock pin done");
		wrap_up();
	end
endmodule // scrl_ctrl_bench
